/* fscr_regs.sv */
`timescale 1ns/1ps
module fscr_regs (
    // System clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // Serial link, own clock
    input  wire logic       link_sck,
    input  wire logic       link_cs_b,
    input  wire logic       link_si,
    output logic            link_so_q,
    output logic            link_so_oe_q,
    // Events and levels from the program/erase engines
    input  wire logic       erase_fail_evt,
    input  wire logic       erase_prot_evt,
    input  wire logic       chip_erase_prot_evt,
    input  wire logic       program_fail_evt,
    input  wire logic       program_prot_evt,
    input  wire logic       erase_suspended,
    input  wire logic       program_suspended,
    input  wire logic [2:0] protection_mode_bits,
    // Register contents and volatile defaults
    output logic [7:0]      status_two_volatile_q,
    output logic [7:0]      config_one_nonvolatile_q,
    output logic            busy_flag_q,
    output logic            halt_state_flag_q,
    output logic            inverted_protect_map_q,
    output logic [3:0]      region_lock_bits_q,
    output logic            four_bit_width_q,
    output logic            reg_lock_q
);
    // ==========================================================
    // Link side: shifts bits on the link clock, frame cleared by chip select
    fscr_pkg::fscr_state_t st_q;
    fscr_pkg::fscr_ev_t    ev_kind_q;
    logic [7:0]  cmd_q;
    logic [7:0]  shift_q;
    logic [7:0]  tx_q;
    logic [7:0]  ev_data_q;
    logic [23:0] addr_q;
    logic [2:0]  bit_q;
    logic [1:0]  nbyte_q;
    logic        ev_tgl_q;
    logic [7:0]  sr2_s1_q;
    logic [7:0]  sr2_s2_q;
    logic [7:0]  cr1_s1_q;
    logic [7:0]  cr1_s2_q;

    wire [7:0]  byte_in   = {shift_q[6:0], link_si};
    wire        byte_done = (bit_q == fscr_pkg::BIT_LAST);
    wire [23:0] addr_nxt  = {addr_q[15:0], byte_in};
    wire        to_cr1    = (addr_q == fscr_pkg::ADDR_CONFIG_ONE_NONVOLATILE);

    function automatic logic [7:0] rd_sel(input logic [23:0] a,
                                          input logic [7:0] s2,
                                          input logic [7:0] c1);
        rd_sel = (a == fscr_pkg::ADDR_STATUS_TWO_VOLATILE)  ? s2 :
                 (a == fscr_pkg::ADDR_CONFIG_ONE_NONVOLATILE) ? c1 : 8'h00;
    endfunction : rd_sel

    // Register values can change at any time, even mid-frame; only a plain two-stage
    // sync of the bytes is used, so a change landing mid-read may tear.
    always_ff @(posedge link_sck) begin
        sr2_s1_q <= status_two_volatile_q;
        sr2_s2_q <= sr2_s1_q;
        cr1_s1_q <= config_one_nonvolatile_q;
        cr1_s2_q <= cr1_s1_q;
    end

    // Chip select high ends the frame; the link clock stops outside it
    always_ff @(posedge link_sck or posedge link_cs_b) begin
        if (link_cs_b) begin
            st_q    <= fscr_pkg::ST_CMD;
            bit_q   <= 3'h0;
            nbyte_q <= 2'h0;
            shift_q <= 8'h00;
            tx_q    <= 8'h00;
            cmd_q   <= 8'h00;
            addr_q  <= 24'h000000;
        end else begin
            bit_q   <= bit_q + 3'h1;
            shift_q <= byte_in;
            tx_q    <= {tx_q[6:0], 1'b0};
            if (byte_done) begin
                unique case (st_q)
                    fscr_pkg::ST_CMD: begin
                        cmd_q   <= byte_in;
                        nbyte_q <= 2'h0;
                        if (byte_in == fscr_pkg::CMD_READ_STATUS_TWO_CMD) begin
                            st_q <= fscr_pkg::ST_READ;
                            tx_q <= sr2_s2_q;
                        end else if (byte_in == fscr_pkg::CMD_READ_ANY_REG_CMD ||
                                     byte_in == fscr_pkg::CMD_WRITE_ANY_REG_CMD) begin
                            st_q <= fscr_pkg::ST_ADDR;
                        end else if (byte_in == fscr_pkg::CMD_WRR) begin
                            st_q <= fscr_pkg::ST_DATA;
                        end else begin
                            st_q <= fscr_pkg::ST_SKIP;
                        end
                    end
                    fscr_pkg::ST_ADDR: begin
                        addr_q  <= addr_nxt;
                        nbyte_q <= nbyte_q + 2'h1;
                        if (nbyte_q == fscr_pkg::ADDR_LAST) begin
                            nbyte_q <= 2'h0;
                            if (cmd_q == fscr_pkg::CMD_READ_ANY_REG_CMD) begin
                                st_q <= fscr_pkg::ST_READ;
                                tx_q <= rd_sel(addr_nxt, sr2_s2_q, cr1_s2_q);
                            end else begin
                                st_q <= fscr_pkg::ST_DATA;
                            end
                        end
                    end
                    fscr_pkg::ST_DATA: begin
                        nbyte_q <= nbyte_q + 2'h1;
                        if (cmd_q != fscr_pkg::CMD_WRR ||
                            nbyte_q == fscr_pkg::WRR_LAST) begin
                            st_q <= fscr_pkg::ST_SKIP;
                        end
                    end
                    fscr_pkg::ST_READ: begin
                        tx_q <= (cmd_q == fscr_pkg::CMD_READ_STATUS_TWO_CMD) ? sr2_s2_q :
                                rd_sel(addr_q, sr2_s2_q, cr1_s2_q);
                    end
                    fscr_pkg::ST_SKIP: begin
                    end
                    default: st_q <= fscr_pkg::ST_SKIP;
                endcase
            end
        end
    end

    // Event launch: toggle plus payload, stable until the next frame
    wire cmd_now = byte_done && (st_q == fscr_pkg::ST_CMD);
    wire wr_now  = byte_done && (st_q == fscr_pkg::ST_DATA) &&
                   ((cmd_q == fscr_pkg::CMD_WRR && nbyte_q == fscr_pkg::WRR_LAST) ||
                    (cmd_q == fscr_pkg::CMD_WRITE_ANY_REG_CMD && to_cr1));
    wire ev_write_enable_nv_cmd = cmd_now && (byte_in == fscr_pkg::CMD_WRITE_ENABLE_NV_CMD);
    wire ev_clear_status_cmd = cmd_now && (byte_in == fscr_pkg::CMD_CLEAR_STATUS_CMD);
    wire ev_fire = ev_write_enable_nv_cmd || ev_clear_status_cmd || wr_now;

    // The link clock may stand still through reset, so rst_b clears the
    // toggle on its own; frames start only after release, so removal is safe.
    always_ff @(posedge link_sck or negedge rst_b) begin
        if (!rst_b) begin
            ev_tgl_q <= 1'b0;
        end else if (!link_cs_b && ev_fire) begin
            ev_tgl_q <= ~ev_tgl_q;
        end
    end

    // Payload is held until the next event, long after the system side took it
    always_ff @(posedge link_sck) begin
        if (!link_cs_b && ev_fire) begin
            ev_kind_q <= ev_write_enable_nv_cmd ? fscr_pkg::EV_WRITE_ENABLE_NV_CMD :
                         ev_clear_status_cmd ? fscr_pkg::EV_CLEAR_STATUS_CMD : fscr_pkg::EV_WCR1;
            ev_data_q <= byte_in;
        end
    end

    // Output changes on the falling edge so the host samples on the rising
    always_ff @(negedge link_sck or posedge link_cs_b) begin
        if (link_cs_b) begin
            link_so_q    <= 1'b0;
            link_so_oe_q <= 1'b0;
        end else begin
            link_so_q    <= tx_q[7];
            link_so_oe_q <= (st_q == fscr_pkg::ST_READ);
        end
    end

    // ==========================================================
    // System side: event crossing and register state
    logic ev_s1_q;
    logic ev_s2_q;
    logic ev_s3_q;
    logic wel_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ev_s1_q <= 1'b0;
            ev_s2_q <= 1'b0;
            ev_s3_q <= 1'b0;
        end else begin
            ev_s1_q <= ev_tgl_q;
            ev_s2_q <= ev_s1_q;
            ev_s3_q <= ev_s2_q;
        end
    end

    wire ev_pulse = ev_s2_q ^ ev_s3_q;
    wire do_write_enable_nv_cmd  = ev_pulse && (ev_kind_q == fscr_pkg::EV_WRITE_ENABLE_NV_CMD);
    wire do_clear_status_cmd  = ev_pulse && (ev_kind_q == fscr_pkg::EV_CLEAR_STATUS_CMD);
    wire do_wcr1  = ev_pulse && (ev_kind_q == fscr_pkg::EV_WCR1);
    wire e_set    = erase_fail_evt || erase_prot_evt || chip_erase_prot_evt;
    wire p_set    = program_fail_evt || program_prot_evt;
    wire locked   = config_one_nonvolatile_q[fscr_pkg::CR1_LOCK] || reg_lock_q;
    wire wr_ok    = do_wcr1 && wel_q && !busy_flag_q && !locked;
    wire irp_open = (protection_mode_bits == fscr_pkg::IRP_OPEN);
    wire e_err_d  = e_set || (status_two_volatile_q[fscr_pkg::SR2_EERR] && !do_clear_status_cmd);
    wire p_err_d  = p_set || (status_two_volatile_q[fscr_pkg::SR2_PERR] && !do_clear_status_cmd);

    logic [7:0] sr2_d;
    logic [7:0] cr1_d;
    always_comb begin
        sr2_d = fscr_pkg::SR2_RESET;
        sr2_d[fscr_pkg::SR2_EERR] = e_err_d;
        sr2_d[fscr_pkg::SR2_PERR] = p_err_d;
        sr2_d[fscr_pkg::SR2_ES]   = erase_suspended;
        sr2_d[fscr_pkg::SR2_PS]   = program_suspended;
        cr1_d = config_one_nonvolatile_q;
        if (wr_ok) begin
            cr1_d[fscr_pkg::CR1_INV]  = ev_data_q[fscr_pkg::CR1_INV];
            cr1_d[fscr_pkg::CR1_QUAD] = ev_data_q[fscr_pkg::CR1_QUAD];
            cr1_d = cr1_d | (ev_data_q & fscr_pkg::OTP_MASK);
            if (irp_open) begin
                cr1_d[fscr_pkg::CR1_LOCK] = cr1_d[fscr_pkg::CR1_LOCK] |
                                            ev_data_q[fscr_pkg::CR1_LOCK];
            end
        end
        cr1_d[fscr_pkg::CR1_HALT] = 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            status_two_volatile_q    <= fscr_pkg::SR2_RESET;
            config_one_nonvolatile_q <= fscr_pkg::CONFIG_ONE_NONVOLATILE_RESET;
            busy_flag_q              <= 1'b0;
            wel_q                    <= 1'b0;
        end else begin
            status_two_volatile_q    <= sr2_d;
            config_one_nonvolatile_q <= cr1_d;
            busy_flag_q              <= e_err_d || p_err_d;
            wel_q                    <= (wel_q || do_write_enable_nv_cmd) && !do_clear_status_cmd && !wr_ok;
        end
    end

    // Volatile copies: loaded at reset, region locks track the OTP bits
    logic reset_seen_q;
    always_ff @(posedge clk_sys) begin
        reset_seen_q       <= rst_b;
        region_lock_bits_q <= config_one_nonvolatile_q[fscr_pkg::CR1_LBHI:fscr_pkg::CR1_LBLO];
        if (!reset_seen_q) begin
            halt_state_flag_q      <= config_one_nonvolatile_q[fscr_pkg::CR1_HALT];
            inverted_protect_map_q <= config_one_nonvolatile_q[fscr_pkg::CR1_INV];
            four_bit_width_q       <= config_one_nonvolatile_q[fscr_pkg::CR1_QUAD];
            reg_lock_q             <= config_one_nonvolatile_q[fscr_pkg::CR1_LOCK];
        end
    end

    // ==========================================================
    // Checks
    erase_sets_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        e_set |=> status_two_volatile_q[fscr_pkg::SR2_EERR])
        else $error("erase event did not set erase-fail");
    prog_sets_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        p_set |=> status_two_volatile_q[fscr_pkg::SR2_PERR])
        else $error("program event did not set program-fail");
    err_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $fell(status_two_volatile_q[fscr_pkg::SR2_EERR]) |-> $past(do_clear_status_cmd))
        else $error("erase-fail dropped without clear-status");
    reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (status_two_volatile_q & 8'h9C) == 8'h00)
        else $error("reserved status bits not zero");
    suspend_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ##1 status_two_volatile_q[fscr_pkg::SR2_ES] == $past(erase_suspended))
        else $error("erase-suspend bit does not follow mode");
    psusp_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ##1 status_two_volatile_q[fscr_pkg::SR2_PS] == $past(program_suspended))
        else $error("program-suspend bit does not follow mode");
    busy_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        status_two_volatile_q[fscr_pkg::SR2_EERR] ||
        status_two_volatile_q[fscr_pkg::SR2_PERR] |-> busy_flag_q)
        else $error("busy low while an error flag is set");
    otp_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (($past(config_one_nonvolatile_q) & fscr_pkg::OTP_MASK) &
         ~config_one_nonvolatile_q) == 8'h00)
        else $error("region lock bit cleared");
    halt_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !config_one_nonvolatile_q[fscr_pkg::CR1_HALT])
        else $error("halt default bit set");
    lock_blocks_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        locked |=> $stable(config_one_nonvolatile_q))
        else $error("locked config register changed");
    lockbit_irp_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(config_one_nonvolatile_q[fscr_pkg::CR1_LOCK]) |-> $past(irp_open))
        else $error("lock default set outside mode 111");
    write_enable_nv_cmd_need_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        do_wcr1 && !wel_q |=> $stable(config_one_nonvolatile_q))
        else $error("config written without write enable");
    clear_status_cmd_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
        do_clear_status_cmd && status_two_volatile_q[fscr_pkg::SR2_EERR]);
    write_c: cover property (@(posedge clk_sys) disable iff (!rst_b) wr_ok);
    read_c: cover property (@(posedge link_sck) st_q == fscr_pkg::ST_READ);

    // ==========================================================
    // Further checks: write paths, flag stickiness and the link read
    perr_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $fell(status_two_volatile_q[fscr_pkg::SR2_PERR]) |-> $past(do_clear_status_cmd))
        else $error("program-fail dropped without clear-status");
    wr_keeps_err_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        do_wcr1 && !e_set && !p_set |=>
        $stable(status_two_volatile_q[fscr_pkg::SR2_EERR:fscr_pkg::SR2_PERR]))
        else $error("register write changed an error flag");
    inv_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wr_ok |=> config_one_nonvolatile_q[fscr_pkg::CR1_INV] ==
                  $past(ev_data_q[fscr_pkg::CR1_INV]))
        else $error("inverted-map default not written");
    quad_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wr_ok |=> config_one_nonvolatile_q[fscr_pkg::CR1_QUAD] ==
                  $past(ev_data_q[fscr_pkg::CR1_QUAD]))
        else $error("four-bit-width default not written");
    region_track_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        region_lock_bits_q ==
        $past(config_one_nonvolatile_q[fscr_pkg::CR1_LBHI:fscr_pkg::CR1_LBLO]))
        else $error("region lock copies lag the config bits");
    // Link side: the status byte must be the synchronised copy, not a live one
    read_status_two_cmd_load_a: assert property (@(posedge link_sck) disable iff (link_cs_b)
        cmd_now && byte_in == fscr_pkg::CMD_READ_STATUS_TWO_CMD |=> tx_q == $past(sr2_s2_q))
        else $error("status read did not load the status byte");
    lock_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(config_one_nonvolatile_q[fscr_pkg::CR1_LOCK]));
    refuse_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
        do_wcr1 && busy_flag_q);
endmodule : fscr_regs

/* fscr_pkg.sv */
// ==========================================================
// Constants shared by the register bank
package fscr_pkg;
    // Command codes
    localparam logic [7:0] CMD_WRR   = 8'h01;
    localparam logic [7:0] CMD_WRITE_ENABLE_NV_CMD  = 8'h06;
    localparam logic [7:0] CMD_READ_STATUS_TWO_CMD = 8'h07;
    localparam logic [7:0] CMD_READ_ANY_REG_CMD  = 8'h65;
    localparam logic [7:0] CMD_WRITE_ANY_REG_CMD  = 8'h71;
    localparam logic [7:0] CMD_CLEAR_STATUS_CMD  = 8'h30;
    // Register addresses for the any-register commands
    localparam logic [23:0] ADDR_STATUS_TWO_VOLATILE  = 24'h000001;
    localparam logic [23:0] ADDR_CONFIG_ONE_NONVOLATILE = 24'h000002;
    // Status two field positions
    localparam int SR2_EERR = 6;
    localparam int SR2_PERR = 5;
    localparam int SR2_ES   = 1;
    localparam int SR2_PS   = 0;
    // Config one non-volatile field positions
    localparam int CR1_HALT = 7;
    localparam int CR1_INV  = 6;
    localparam int CR1_LBHI = 5;
    localparam int CR1_LBLO = 2;
    localparam int CR1_QUAD = 1;
    localparam int CR1_LOCK = 0;
    // Reset values and masks
    localparam logic [7:0] SR2_RESET   = 8'h00;
    localparam logic [7:0] CONFIG_ONE_NONVOLATILE_RESET = 8'h00;
    localparam logic [7:0] OTP_MASK    = 8'h3C;
    localparam logic [2:0] IRP_OPEN    = 3'h7;
    // Byte framing on the link
    localparam logic [2:0] BIT_LAST  = 3'h7;
    localparam logic [1:0] ADDR_LAST = 2'h2;
    localparam logic [1:0] WRR_LAST  = 2'h1;
    // Events handed from link to system clock
    typedef enum logic [1:0] {
        EV_NONE = 2'h0,
        EV_WRITE_ENABLE_NV_CMD = 2'h1,
        EV_CLEAR_STATUS_CMD = 2'h2,
        EV_WCR1 = 2'h3
    } fscr_ev_t;
    // Link frame states, Gray in listed order; only CMD to ADDR or READ and ADDR to DATA change one bit
    typedef enum logic [2:0] {
        ST_CMD  = 3'h0,
        ST_ADDR = 3'h1,
        ST_DATA = 3'h3,
        ST_READ = 3'h2,
        ST_SKIP = 3'h6
    } fscr_state_t;
endpackage : fscr_pkg

/* fscr_host.sv */
`timescale 1ns/1ps
// ==========================================================
// Host on the serial link, mode 0
module fscr_host (
    // Link pins
    output logic      link_sck,
    output logic      link_cs_b,
    output logic      link_si,
    input  wire logic link_so_q,
    input  wire logic link_so_oe_q
);
    initial begin
        link_sck  = 1'b0;
        link_cs_b = 1'b1;
        link_si   = 1'b0;
    end
    // ==========================================================
    // One frame: n bytes out MSB first, then rd bits in
    // Clock rests low outside frames; idle data toggles so no level is trusted
    task automatic frame(input int n, input logic [39:0] tx, input int rd,
                         output logic [7:0] rx, output logic oe);
        rx = 8'h00;
        oe = 1'b1;
        link_cs_b = 1'b0;
        for (int i = 0; i < 8 * n; i++) begin
            link_si = tx[8 * n - 1 - i];
            #80 link_sck = 1'b1;
            #80 link_sck = 1'b0;
        end
        for (int i = 0; i < rd; i++) begin
            link_si = ~link_si;
            #80 link_sck = 1'b1;
            rx = {rx[6:0], link_so_q};
            oe = oe & link_so_oe_q;
            #80 link_sck = 1'b0;
        end
        #80 link_cs_b = 1'b1;
        link_si = ~link_si;
        #80;
    endtask : frame
endmodule : fscr_host

/* tb_top.sv */
`timescale 1ns/1ps
// ==========================================================
// Bench for the status and config register bank
module tb_top;
    logic       clk_sys              = 1'b0;
    logic       rst_b                = 1'b0;
    logic [4:0] evt                  = 5'h00;
    logic       erase_suspended      = 1'b0;
    logic       program_suspended    = 1'b0;
    logic [2:0] protection_mode_bits = 3'h0;
    logic       link_sck;
    logic       link_cs_b;
    logic       link_si;
    logic       link_so_q;
    logic       link_so_oe_q;
    logic [7:0] status_q;
    logic [7:0] config_q;
    logic [3:0] region_q;
    logic       busy_q;
    logic       halt_q;
    logic       inv_q;
    logic       quad_q;
    logic       lock_q;
    logic [7:0] rx;
    logic       oe;
    int         miscompares = 0;
    int         checks_done = 0;

    always #25 clk_sys = ~clk_sys;

    fscr_regs fscr_regs_i (
        .clk_sys(clk_sys), .rst_b(rst_b), .link_sck(link_sck), .link_cs_b(link_cs_b),
        .link_si(link_si), .link_so_q(link_so_q), .link_so_oe_q(link_so_oe_q),
        .erase_fail_evt(evt[0]), .erase_prot_evt(evt[1]), .chip_erase_prot_evt(evt[2]),
        .program_fail_evt(evt[3]), .program_prot_evt(evt[4]),
        .erase_suspended(erase_suspended), .program_suspended(program_suspended),
        .protection_mode_bits(protection_mode_bits), .status_two_volatile_q(status_q),
        .config_one_nonvolatile_q(config_q), .busy_flag_q(busy_q),
        .halt_state_flag_q(halt_q), .inverted_protect_map_q(inv_q),
        .region_lock_bits_q(region_q), .four_bit_width_q(quad_q), .reg_lock_q(lock_q));

    fscr_host fscr_host_i (
        .link_sck(link_sck), .link_cs_b(link_cs_b), .link_si(link_si),
        .link_so_q(link_so_q), .link_so_oe_q(link_so_oe_q));

    // ==========================================================
    // Shared helpers
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Config lands 2-3 clk_sys after the frame's last link edge; ten cycles covers the crossing
    task automatic xfer(input int n, input logic [39:0] tx, input int rd);
        fscr_host_i.frame(n, tx, rd, rx, oe);
        repeat (10) @(negedge clk_sys);
        if (rd > 0) check("so_enable", {7'h00, oe}, 8'h01);
    endtask : xfer

    task automatic write_any_reg_cmd(input logic [23:0] a, input logic [7:0] d);
        xfer(1, {32'h0, fscr_pkg::CMD_WRITE_ENABLE_NV_CMD}, 0);
        xfer(5, {fscr_pkg::CMD_WRITE_ANY_REG_CMD, a, d}, 0);
    endtask : write_any_reg_cmd

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        check("status_rst", status_q, 8'h00);
        check("config_rst", config_q, 8'h00);
        check("copies_rst", {region_q, halt_q, inv_q, quad_q, lock_q}, 8'h00);
        xfer(1, {32'h0, fscr_pkg::CMD_READ_STATUS_TWO_CMD}, 8);
        check("rd_status_rst", rx, 8'h00);
    endtask : t_reset

    task automatic t_events();
        logic [7:0] exp;
        for (int k = 0; k < 5; k++) begin
            exp = (k < 3) ? 8'h40 : 8'h20;
            evt = 5'h01 << k;
            @(negedge clk_sys);
            evt = 5'h00;
            check("flag_set", status_q, exp);
            check("busy_now", {7'h00, busy_q}, 8'h01);
            @(negedge clk_sys);
            check("busy_set", {7'h00, busy_q}, 8'h01);
            xfer(1, {32'h0, fscr_pkg::CMD_READ_STATUS_TWO_CMD}, 8);
            check("rd_status", rx, exp);
            xfer(4, {8'h0, fscr_pkg::CMD_READ_ANY_REG_CMD, fscr_pkg::ADDR_STATUS_TWO_VOLATILE}, 8);
            check("rd_any", rx, exp);
            write_any_reg_cmd(fscr_pkg::ADDR_CONFIG_ONE_NONVOLATILE, 8'h02);
            write_any_reg_cmd(fscr_pkg::ADDR_STATUS_TWO_VOLATILE, 8'h00);
            check("err_hold", status_q, exp);
            check("busy_refuse", config_q, 8'h00);
            xfer(1, {32'h0, fscr_pkg::CMD_CLEAR_STATUS_CMD}, 0);
            check("clr_flag", status_q, 8'h00);
            check("clr_busy", {7'h00, busy_q}, 8'h00);
        end
    endtask : t_events

    task automatic t_suspend();
        erase_suspended = 1'b1;
        repeat (3) @(negedge clk_sys);
        check("erase_susp", status_q, 8'h02);
        program_suspended = 1'b1;
        write_any_reg_cmd(fscr_pkg::ADDR_STATUS_TWO_VOLATILE, 8'h00);
        check("both_susp", status_q, 8'h03);
        erase_suspended = 1'b0;
        repeat (3) @(negedge clk_sys);
        check("prog_susp", status_q, 8'h01);
        program_suspended = 1'b0;
        xfer(1, {32'h0, fscr_pkg::CMD_CLEAR_STATUS_CMD}, 0);
        check("no_susp", status_q, 8'h00);
    endtask : t_suspend

    task automatic t_config();
        xfer(5, {fscr_pkg::CMD_WRITE_ANY_REG_CMD, fscr_pkg::ADDR_CONFIG_ONE_NONVOLATILE, 8'h40}, 0);
        check("no_write_enable_nv_cmd", config_q, 8'h00);
        xfer(1, {32'h0, fscr_pkg::CMD_WRITE_ENABLE_NV_CMD}, 0);
        xfer(2, {24'h0, fscr_pkg::CMD_WRR, 8'hFF}, 0);
        check("short_wrr", config_q, 8'h00);
        xfer(1, {32'h0, fscr_pkg::CMD_WRITE_ENABLE_NV_CMD}, 0);
        xfer(3, {16'h0, fscr_pkg::CMD_WRR, 8'h00, 8'hFF}, 0);
        check("wrr_cfg", config_q, 8'h7E);
        check("locks_copy", {4'h0, region_q}, 8'h0F);
        write_any_reg_cmd(fscr_pkg::ADDR_CONFIG_ONE_NONVOLATILE, 8'h00);
        check("otp_keep", config_q, 8'h3C);
        protection_mode_bits = 3'h7;
        write_any_reg_cmd(fscr_pkg::ADDR_CONFIG_ONE_NONVOLATILE, 8'h01);
        check("lock_prog", config_q, 8'h3D);
        write_any_reg_cmd(fscr_pkg::ADDR_CONFIG_ONE_NONVOLATILE, 8'h42);
        check("lock_hold", config_q, 8'h3D);
        xfer(4, {8'h0, fscr_pkg::CMD_READ_ANY_REG_CMD, fscr_pkg::ADDR_CONFIG_ONE_NONVOLATILE}, 8);
        check("rd_cfg", rx, 8'h3D);
    endtask : t_config

    initial begin
        repeat (6) @(negedge clk_sys);
        rst_b = 1'b1;
        @(negedge clk_sys);
        t_reset();
        t_events();
        t_suspend();
        t_config();
        complete_run();
    end

    // Watchdog: a hang counts as a mismatch
    initial begin
        #2000000;
        miscompares++;
        $display("Error watchdog expected done seen hang");
        complete_run();
    end
endmodule : tb_top
